//--- common/fcrp_defs.vh
// Purpose: Constants for the filter configuration register port.
// Assumes: Included by bare name from the design files.
// Notes: Offsets are the 3-bit register addresses on reg_address_bus.
`ifndef FCRP_DEFS_VH
`define FCRP_DEFS_VH

// Register addresses.
`define FCRP_ADDR_FILTER_CFG 3'h0
`define FCRP_ADDR_FIR_TAPS 3'h1
`define FCRP_ADDR_COEF_PORT 3'h2
`define FCRP_ADDR_INPUT_FMT 3'h3
`define FCRP_ADDR_OUT_TIMING 3'h4
`define FCRP_ADDR_OUT_FMT 3'h5
`define FCRP_ADDR_SYMMETRY 3'h6
`define FCRP_ADDR_MIX_FMT 3'h7

// Reset value of every stored register.
`define FCRP_REG_RESET 8'h00

// Writable bit masks; bits outside a mask are stored and read as zero.
`define FCRP_MASK_FULL 8'hFF
`define FCRP_MASK_INPUT_FMT 8'h7F
`define FCRP_MASK_OUT_TIMING 8'h3F
`define FCRP_MASK_SYMMETRY 8'h03
`define FCRP_MASK_MIX_FMT 8'h7F

// Field positions in filter_configuration.
`define FCRP_HB_LSB 0
`define FCRP_FILT_EN_BIT 3
`define FCRP_COEF_RD_EN_BIT 4
`define FCRP_DECIM_LSB 5

// Field positions shared by the format and timing registers.
`define FCRP_LEN_LSB 0
`define FCRP_FMT_BIT5 5
`define FCRP_FMT_BIT6 6
`define FCRP_FMT_BIT7 7

// Legal ranges.
`define FCRP_HB_MAX 3'h5
`define FCRP_SER_LEN_MIN 5'h08
`define FCRP_SER_LEN_MAX 5'h18
`define FCRP_OUT_LEN_MIN 5'h08
`define FCRP_TAPS_MIN 8'h04
`define FCRP_SYM_INVALID 2'h3

`endif

//--- rtl/fcrp_config_port.v
// Purpose: Configuration register bank and coefficient store reached over
//          an 8-bit strobed parallel port.
// Assumes: All port inputs are synchronous to sys_clk; sys_clk is also the
//          filter clock that runs the processing logic.
// Notes: Strobe edges are found by comparing with the previous sample.
`timescale 1ns/1ps
`include "fcrp_defs.vh"

module fcrp_config_port #(
    parameter COEF_DEPTH = 128,  // Coefficient words held.
    parameter WPTR_W = 8         // Holds 0..COEF_DEPTH.
) (
    input wire sys_clk,                   // Filter clock.
    input wire reset,                     // Asynchronous, active high.
    input wire [2:0] reg_address_bus,     // Register address.
    input wire [7:0] config_data_in,      // Data bus input side.
    output wire [7:0] config_data_out,    // Data bus output side.
    output wire config_data_oe_n,         // Low while driving the bus.
    input wire wr_n,                      // Write strobe, active low.
    input wire rd_n,                      // Read strobe, active low.
    input wire [6:0] coef_index,          // Processing-side coef select.
    output reg [31:0] coef_word,          // Selected coefficient.
    output reg [2:0] halfband_stage_count, // Halfband stages in use.
    output reg filter_enable,             // Filter enabled.
    output reg coef_read_enable,          // Coefficient readback mode.
    output reg [3:0] fir_decimation,      // FIR decimation, 1..8.
    output reg [8:0] fir_tap_count,       // Taps, 1..256.
    output reg [4:0] input_word_length,   // Input bits.
    output reg input_offset_binary,       // Input number system.
    output reg input_msb_first,           // Input bit order.
    output reg [5:0] output_bit_clock_div, // Clocks per output bit.
    output reg output_msb_first,          // Output bit order.
    output reg [5:0] output_word_length,  // Output bits, 1..32.
    output reg output_round,              // Round, else truncate.
    output reg output_offset_binary,      // Output number system.
    output reg output_gain_x2,            // Scale output by two.
    output reg [1:0] coef_symmetry,       // Symmetry code.
    output reg [4:0] mix_word_length,     // Mix factor bits.
    output reg mix_msb_first,             // Mix bit order.
    output reg mix_serial_select,         // Serial mix, else table.
    output reg config_invalid,            // Some field holds a bad code.
    output reg coef_load_full             // Write pointer has halted.
);

    // Zero code of a 5-bit length field stands for 32.
    function [5:0] fcrp_len32;
        input [4:0] v;
        begin
            fcrp_len32 = (v == 5'h00) ? 6'h20 : {1'b0, v};
        end
    endfunction

    // Serial word lengths are legal from 8 to 24 bits.
    function fcrp_ser_len_ok;
        input [4:0] v;
        begin
            fcrp_ser_len_ok = (v >= `FCRP_SER_LEN_MIN) &&
                              (v <= `FCRP_SER_LEN_MAX);
        end
    endfunction

    // Per-address writable bits; unused and reserved bits stay zero.
    function [7:0] fcrp_mask;
        input [2:0] a;
        begin
            case (a)
                `FCRP_ADDR_INPUT_FMT: fcrp_mask = `FCRP_MASK_INPUT_FMT;
                `FCRP_ADDR_OUT_TIMING: fcrp_mask = `FCRP_MASK_OUT_TIMING;
                `FCRP_ADDR_SYMMETRY: fcrp_mask = `FCRP_MASK_SYMMETRY;
                `FCRP_ADDR_MIX_FMT: fcrp_mask = `FCRP_MASK_MIX_FMT;
                default: fcrp_mask = `FCRP_MASK_FULL;
            endcase
        end
    endfunction

    reg [7:0] regs_q [0:7];
    reg [31:0] coef_mem_q [0:COEF_DEPTH-1];
    reg wr_prev_q;
    reg rd_prev_q;
    reg rd_active_q;
    reg [7:0] rd_data_q;
    reg [23:0] hold_q;
    reg [1:0] wr_byte_q;
    reg [WPTR_W-1:0] wr_ptr_q;
    reg [WPTR_W:0] rd_ptr_q;
    integer i;

    wire wr_fall;
    wire rd_fall;
    wire coef_sel;
    wire wr_full;
    wire [7:0] wr_value;
    wire [31:0] rd_word;
    wire [7:0] rd_byte;
    wire [7:0] cfg0;
    wire [7:0] tim;
    wire [7:0] ofmt;
    wire [7:0] ifmt;
    wire [7:0] mfmt;

    // Edge detection; both strobes are already synchronous to sys_clk.
    // A strobe must stay high for at least one sample between accesses,
    // or two accesses merge into one and the second is lost.
    assign wr_fall = wr_prev_q & ~wr_n;
    assign rd_fall = rd_prev_q & ~rd_n;
    assign coef_sel = (reg_address_bus == `FCRP_ADDR_COEF_PORT);
    assign wr_full = (wr_ptr_q >= COEF_DEPTH[WPTR_W-1:0]);
    assign wr_value = config_data_in & fcrp_mask(reg_address_bus);
    assign cfg0 = regs_q[`FCRP_ADDR_FILTER_CFG];
    assign tim = regs_q[`FCRP_ADDR_OUT_TIMING];
    assign ofmt = regs_q[`FCRP_ADDR_OUT_FMT];
    assign ifmt = regs_q[`FCRP_ADDR_INPUT_FMT];
    assign mfmt = regs_q[`FCRP_ADDR_MIX_FMT];

    // Read pointer walks bytes in write order: word, then byte lane.
    // The word part has exactly as many bits as the store has address
    // bits, so a long readback wraps to word zero rather than fetching
    // from locations that do not exist.
    assign rd_word = coef_mem_q[rd_ptr_q[WPTR_W:2]];
    assign rd_byte = rd_word[{rd_ptr_q[1:0], 3'b000} +: 8];

    // Strobe history. It resets to the idle level of the strobes, so a
    // strobe that is already low when reset ends is taken for an access
    // at the first clock edge; the host need not raise it first.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wr_prev_q <= 1'b1;
            rd_prev_q <= 1'b1;
        end else begin
            wr_prev_q <= wr_n;
            rd_prev_q <= rd_n;
        end
    end

    // Register file. A write wins over a read if both strobes fall in
    // the same cycle; the read is then simply not served.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (i = 0; i < 8; i = i + 1) begin
                regs_q[i] <= `FCRP_REG_RESET;
            end
        end else if (wr_fall && !coef_sel) begin
            regs_q[reg_address_bus] <= wr_value;
        end
    end

    // Coefficient write path: three bytes wait in the holding register,
    // the fourth completes the word, which is then stored.
    // A partial word is dropped whenever another register is accessed,
    // so a host that lost count can start over by touching any other.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            hold_q <= 24'h000000;
            wr_byte_q <= 2'h0;
            wr_ptr_q <= {WPTR_W{1'b0}};
        end else if ((wr_fall | rd_fall) && !coef_sel) begin
            wr_byte_q <= 2'h0;
            wr_ptr_q <= {WPTR_W{1'b0}};
        end else if (wr_fall && !cfg0[`FCRP_COEF_RD_EN_BIT] && !wr_full) begin
            // Writes are blocked in readback mode and past the last word.
            case (wr_byte_q)
                2'h0: begin
                    hold_q[7:0] <= config_data_in;
                end
                2'h1: begin
                    hold_q[15:8] <= config_data_in;
                end
                2'h2: begin
                    hold_q[23:16] <= config_data_in;
                end
                default: begin
                    wr_ptr_q <= wr_ptr_q + 1'b1;
                end
            endcase
            wr_byte_q <= wr_byte_q + 1'b1;
        end
    end

    // Coefficient storage, written when the fourth byte arrives. The
    // store has no reset, which keeps it plain flip-flops without a
    // reset tree; a word reads as unknown until it has been loaded, so
    // the processing side must not run before the set is complete.
    always @(posedge sys_clk) begin
        if (wr_fall && coef_sel && !cfg0[`FCRP_COEF_RD_EN_BIT] &&
            !wr_full && (wr_byte_q == 2'h3)) begin
            coef_mem_q[wr_ptr_q[WPTR_W-2:0]] <= {config_data_in, hold_q};
        end
    end

    // Coefficient readback pointer. It counts bytes: the two low bits
    // pick the byte lane and the rest pick the word.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_ptr_q <= {(WPTR_W+1){1'b0}};
        end else if (wr_fall && !coef_sel) begin
            // Any write of any other register restarts readback from the
            // first byte, whether the read enable is set or not.
            if (reg_address_bus == `FCRP_ADDR_FILTER_CFG &&
                config_data_in[`FCRP_COEF_RD_EN_BIT]) begin
                rd_ptr_q <= {(WPTR_W+1){1'b0}};
            end else begin
                rd_ptr_q <= {(WPTR_W+1){1'b0}};
            end
        end else if (rd_fall && !wr_fall && !coef_sel) begin
            rd_ptr_q <= {(WPTR_W+1){1'b0}};
        end else if (rd_fall && !wr_fall && coef_sel &&
                     cfg0[`FCRP_COEF_RD_EN_BIT]) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end

    // Read data is captured once at the falling edge and held, so a
    // late address change cannot disturb the byte already on the bus.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_data_q <= 8'h00;
            rd_active_q <= 1'b0;
        end else if (rd_n) begin
            rd_active_q <= 1'b0;
        end else if (rd_fall && !wr_fall) begin
            rd_active_q <= 1'b1;
            if (coef_sel) begin
                // Coefficient port reads zero outside readback mode.
                rd_data_q <= cfg0[`FCRP_COEF_RD_EN_BIT] ? rd_byte : 8'h00;
            end else begin
                rd_data_q <= regs_q[reg_address_bus];
            end
        end
    end

    // Bus drive starts the cycle after the read strobe falls and ends as soon as it rises.
    assign config_data_out = rd_data_q;
    assign config_data_oe_n = ~(rd_active_q & ~rd_n);

    // Processing-side copy, refreshed only while no strobe is low, so a
    // half-finished access never reaches the datapath. The cost is that
    // a held strobe freezes the published settings. Fields whose zero
    // code stands for the largest value are widened here, so downstream
    // logic never has to decode the zero code itself.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            halfband_stage_count <= 3'h0;
            filter_enable <= 1'b0;
            coef_read_enable <= 1'b0;
            fir_decimation <= 4'h8;
            fir_tap_count <= 9'h100;
            input_word_length <= 5'h00;
            input_offset_binary <= 1'b0;
            input_msb_first <= 1'b0;
            output_bit_clock_div <= 6'h20;
            output_msb_first <= 1'b0;
            output_word_length <= 6'h20;
            output_round <= 1'b0;
            output_offset_binary <= 1'b0;
            output_gain_x2 <= 1'b0;
            coef_symmetry <= 2'h0;
            mix_word_length <= 5'h00;
            mix_msb_first <= 1'b0;
            mix_serial_select <= 1'b0;
            config_invalid <= 1'b1;
            coef_load_full <= 1'b0;
        end else if (wr_n && rd_n) begin
            halfband_stage_count <= cfg0[`FCRP_HB_LSB +: 3];
            filter_enable <= cfg0[`FCRP_FILT_EN_BIT];
            coef_read_enable <= cfg0[`FCRP_COEF_RD_EN_BIT];
            fir_decimation <= (cfg0[`FCRP_DECIM_LSB +: 3] == 3'h0) ?
                4'h8 : {1'b0, cfg0[`FCRP_DECIM_LSB +: 3]};
            fir_tap_count <= (regs_q[`FCRP_ADDR_FIR_TAPS] == 8'h00) ?
                9'h100 : {1'b0, regs_q[`FCRP_ADDR_FIR_TAPS]};
            input_word_length <= ifmt[`FCRP_LEN_LSB +: 5];
            input_offset_binary <= ifmt[`FCRP_FMT_BIT5];
            input_msb_first <= ifmt[`FCRP_FMT_BIT6];
            output_bit_clock_div <= fcrp_len32(tim[4:0]);
            output_msb_first <= tim[`FCRP_FMT_BIT5];
            output_word_length <= fcrp_len32(ofmt[4:0]);
            output_round <= ofmt[`FCRP_FMT_BIT5];
            output_offset_binary <= ofmt[`FCRP_FMT_BIT6];
            output_gain_x2 <= ofmt[`FCRP_FMT_BIT7];
            coef_symmetry <= regs_q[`FCRP_ADDR_SYMMETRY][1:0];
            mix_word_length <= mfmt[`FCRP_LEN_LSB +: 5];
            mix_msb_first <= mfmt[`FCRP_FMT_BIT5];
            mix_serial_select <= mfmt[`FCRP_FMT_BIT6];
            coef_load_full <= wr_full;
            // Flag codes that the processing logic cannot honour.
            config_invalid <=
                (cfg0[2:0] > `FCRP_HB_MAX) ||
                (regs_q[`FCRP_ADDR_FIR_TAPS] != 8'h00 &&
                 regs_q[`FCRP_ADDR_FIR_TAPS] < `FCRP_TAPS_MIN) ||
                !fcrp_ser_len_ok(ifmt[4:0]) ||
                (ofmt[4:0] != 5'h00 &&
                 ofmt[4:0] < `FCRP_OUT_LEN_MIN) ||
                (regs_q[`FCRP_ADDR_SYMMETRY][1:0] ==
                 `FCRP_SYM_INVALID) ||
                !fcrp_ser_len_ok(mfmt[4:0]);
        end
    end

    // Coefficient fetch for the processing side, one cycle of latency.
    // The index may change every cycle; the registered word keeps the
    // memory's decode path out of the multiplier's input timing.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            coef_word <= 32'h00000000;
        end else begin
            coef_word <= coef_mem_q[coef_index];
        end
    end

endmodule

//--- tb/fcrp_config_port_assertions.sv
// Purpose: Port checks for the configuration register port.
// Assumes: A strobe event is a low sample after a high one.
// Notes: A shadow copy of the bank stands in for the hidden registers.
`timescale 1ns/1ps
module fcrp_config_port_assertions (
    input wire sys_clk,                    // Clock.
    input wire reset,                      // Async, active high.
    input wire [2:0] reg_address_bus,      // Address.
    input wire [7:0] config_data_in,       // Bus input side.
    input wire [7:0] config_data_out,      // Bus output side.
    input wire config_data_oe_n,           // Drive enable.
    input wire wr_n,                       // Write strobe.
    input wire rd_n,                       // Read strobe.
    input wire [2:0] halfband_stage_count, // Stage count.
    input wire filter_enable,              // Filter on.
    input wire coef_read_enable,           // Readback mode.
    input wire [3:0] fir_decimation,       // Decimation.
    input wire [8:0] fir_tap_count,        // Taps.
    input wire [5:0] output_word_length,   // Output bits.
    input wire output_round,               // Round.
    input wire output_offset_binary,       // Offset binary.
    input wire output_gain_x2,             // Gain.
    input wire [1:0] coef_symmetry         // Symmetry.
);
    logic wr_p_q;
    logic rd_p_q;
    logic [7:0] sh_q [8];
    wire wr_ev = wr_p_q && !wr_n;
    wire rd_ev = rd_p_q && !rd_n && !wr_ev;
    wire quiet = wr_n && rd_n;
    wire [7:0] msk = (reg_address_bus == 3'h3 || reg_address_bus == 3'h7) ?
        8'h7F : (reg_address_bus == 3'h4) ? 8'h3F :
        (reg_address_bus == 3'h6) ? 8'h03 : 8'hFF;

    // Mirror is kept masked so reserved bits are expected to read zero.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wr_p_q <= 1'b1;
            rd_p_q <= 1'b1;
            for (int i = 0; i < 8; i++) begin
                sh_q[i] <= 8'h00;
            end
        end else begin
            wr_p_q <= wr_n;
            rd_p_q <= rd_n;
            if (wr_ev) begin
                sh_q[reg_address_bus] <= config_data_in & msk;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_oe_off; rd_n |-> config_data_oe_n; endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("bus driven with read strobe high");
    property p_oe_on; rd_ev |=> (!config_data_oe_n || rd_n); endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("read not answered");
    property p_hold;
        (!config_data_oe_n && !$past(config_data_oe_n)) |->
            $stable(config_data_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("read data moved while driven");
    property p_rdata;
        (rd_ev && reg_address_bus != 3'h2) |=>
            config_data_out == sh_q[$past(reg_address_bus)];
    endproperty
    a_rdata: assert property (p_rdata)
        else $error("read data differs from register");
    property p_cfg0;
        quiet |=> {coef_read_enable, filter_enable, halfband_stage_count}
            == sh_q[0][4:0];
    endproperty
    a_cfg0: assert property (p_cfg0)
        else $error("low config fields wrong");
    property p_decim;
        quiet |=> fir_decimation == ((sh_q[0][7:5] == 3'h0) ? 4'h8 :
            {1'b0, sh_q[0][7:5]});
    endproperty
    a_decim: assert property (p_decim)
        else $error("decimation wrong");
    property p_taps;
        quiet |=> fir_tap_count == ((sh_q[1] == 8'h00) ? 9'h100 :
            {1'b0, sh_q[1]});
    endproperty
    a_taps: assert property (p_taps)
        else $error("tap count wrong");
    property p_ofmt;
        quiet |=> output_word_length == ((sh_q[5][4:0] == 5'h00) ? 6'h20 :
            {1'b0, sh_q[5][4:0]}) && {output_gain_x2, output_offset_binary,
            output_round} == sh_q[5][7:5];
    endproperty
    a_ofmt: assert property (p_ofmt)
        else $error("output format wrong");
    property p_sym; quiet |=> coef_symmetry == sh_q[6][1:0]; endproperty
    a_sym: assert property (p_sym)
        else $error("symmetry wrong");
    property p_freeze;
        !quiet |=> $stable(fir_tap_count) && $stable(coef_symmetry);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("config moved during an access");
endmodule

bind fcrp_config_port fcrp_config_port_assertions u_chk (
    .sys_clk(sys_clk), .reset(reset), .reg_address_bus(reg_address_bus),
    .config_data_in(config_data_in), .config_data_out(config_data_out),
    .config_data_oe_n(config_data_oe_n), .wr_n(wr_n), .rd_n(rd_n),
    .halfband_stage_count(halfband_stage_count),
    .filter_enable(filter_enable), .coef_read_enable(coef_read_enable),
    .fir_decimation(fir_decimation), .fir_tap_count(fir_tap_count),
    .output_word_length(output_word_length), .output_round(output_round),
    .output_offset_binary(output_offset_binary),
    .output_gain_x2(output_gain_x2), .coef_symmetry(coef_symmetry));

//--- tb/fcrp_host_model.sv
// Purpose: Host side of the strobed register port.
// Assumes: Signals move just after sys_clk rises.
// Notes: Released data lines carry the inverse of the last byte.
`timescale 1ns/1ps
module fcrp_host_model (
    input wire sys_clk,                 // Clock.
    input wire config_data_oe_n,        // Device drive enable.
    output logic [2:0] reg_address_bus, // Address.
    output logic [7:0] config_data_in,  // Bus toward device.
    output logic wr_n = 1'b1,           // Write strobe.
    output logic rd_n = 1'b1            // Read strobe.
);
    initial begin
        reg_address_bus = 3'h0;
        config_data_in = 8'hA5;
    end

    // Address and data are valid at the edge that sees the strobe low.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_address_bus <= a;
        config_data_in <= d;
        wr_n <= 1'b0;
        @(posedge sys_clk);
        wr_n <= 1'b1;
        config_data_in <= ~d;
        @(posedge sys_clk);
    endtask

    // Address holds until the strobe is high again; the wait is bounded.
    task automatic rd(input logic [2:0] a);
        int n;
        @(posedge sys_clk);
        reg_address_bus <= a;
        rd_n <= 1'b0;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (config_data_oe_n && n < 8);
        rd_n <= 1'b1;
        @(posedge sys_clk);
    endtask
endmodule

//--- tb/tb_filter_config_register_port.sv
// Purpose: Self-checking bench for the configuration register port.
// Assumes: The host model drives the port; read bytes are queued.
// Notes: Random bytes come from one fixed seed.
`timescale 1ns/1ps
module tb_filter_config_register_port;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [6:0] coef_index = 7'h00;
    wire [2:0] reg_address_bus;
    wire [7:0] config_data_in, config_data_out;
    wire config_data_oe_n, wr_n, rd_n, config_invalid, coef_load_full;
    wire [31:0] coef_word;
    wire [3:0] fir_decimation;
    wire [8:0] fir_tap_count;
    wire [6:0] in_f, mix_f;
    wire [5:0] output_bit_clock_div, output_word_length;
    wire output_msb_first;
    int num_errors = 0;
    int n_tests = 0;
    logic [7:0] exp_q[$];
    logic oe_p = 1'b1;
    logic [7:0] v [8];
    logic [7:0] cb [12];
    logic [7:0] gv [8] = '{8'h25, 8'h04, 8'h00, 8'h18, 8'h00, 8'h08, 8'h02,
        8'h08};
    logic [10:0] bad [7] = '{11'h006, 11'h103, 11'h307, 11'h319, 11'h507,
        11'h603, 11'h719};

    fcrp_config_port DUT (.sys_clk(sys_clk), .reset(reset),
        .reg_address_bus(reg_address_bus), .config_data_in(config_data_in),
        .config_data_out(config_data_out), .config_data_oe_n(config_data_oe_n),
        .wr_n(wr_n), .rd_n(rd_n), .coef_index(coef_index),
        .coef_word(coef_word), .halfband_stage_count(), .filter_enable(),
        .coef_read_enable(), .fir_decimation(fir_decimation),
        .fir_tap_count(fir_tap_count), .input_word_length(in_f[4:0]),
        .input_offset_binary(in_f[5]), .input_msb_first(in_f[6]),
        .output_bit_clock_div(output_bit_clock_div),
        .output_msb_first(output_msb_first),
        .output_word_length(output_word_length), .output_round(),
        .output_offset_binary(), .output_gain_x2(), .coef_symmetry(),
        .mix_word_length(mix_f[4:0]), .mix_msb_first(mix_f[5]),
        .mix_serial_select(mix_f[6]), .config_invalid(config_invalid),
        .coef_load_full(coef_load_full));
    fcrp_host_model u_host (.sys_clk(sys_clk),
        .config_data_oe_n(config_data_oe_n), .reg_address_bus(reg_address_bus),
        .config_data_in(config_data_in), .wr_n(wr_n), .rd_n(rd_n));

    // Free-running clock, 4 ns period.
    always #2 sys_clk = ~sys_clk;

    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    function automatic logic [7:0] msk(input int a);
        return (a == 3 || a == 7) ? 8'h7F : (a == 4) ? 8'h3F :
            (a == 6) ? 8'h03 : 8'hFF;
    endfunction

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.rd(a);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        u_host.wr(a, d);
    endtask

    task automatic look(input logic [6:0] i, input logic [31:0] e);
        coef_index <= i;
        repeat (2) @(posedge sys_clk);
        chk(coef_word === e, "coefficient word");
    endtask

    task automatic end_sim;
        chk(exp_q.size() == 0, "reads missing");
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // The oldest queued byte is due when the bus starts driving.
    always @(posedge sys_clk) begin
        oe_p <= config_data_oe_n;
        if (config_data_oe_n === 1'b0 && oe_p === 1'b1) begin
            if (exp_q.size() == 0)
                chk(1'b0, "unexpected read");
            else
                chk(config_data_out === exp_q.pop_front(), "rdata");
        end
    end

    // Hang guard; the tests need under a tenth of this span.
    initial begin
        #100000;
        chk(1'b0, "watchdog");
        end_sim;
    end

    initial begin
        v[0] = $urandom(32'h6e90);
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(fir_decimation === 4'h8, "rst decimation");
        chk(fir_tap_count === 9'h100, "rst taps");
        chk(output_bit_clock_div === 6'h20, "rst divider");
        chk(config_invalid === 1'b1, "rst invalid");
        $display("test reset done");
        // Random round trip; reserved bits must come back as zero.
        for (int a = 0; a < 8; a++) begin
            v[a] = $urandom;
            if (a != 2) wr(a[2:0], v[a]);
        end
        for (int a = 7; a >= 0; a--) begin
            if (a != 2) rd(a[2:0], v[a] & msk(a));
        end
        chk(in_f === v[3][6:0], "input format");
        chk(mix_f === v[7][6:0], "mix format");
        chk(output_bit_clock_div === ((v[4][4:0] == 5'h00) ? 6'h20 :
            {1'b0, v[4][4:0]}), "divider");
        chk(output_msb_first === v[4][5], "output order");
        $display("test round trip done");
        // Each bad code alone flags the set; the set is checked clear once all are restored.
        for (int a = 0; a < 8; a++) wr(a[2:0], gv[a]);
        @(posedge sys_clk);
        chk(config_invalid === 1'b0, "valid set");
        foreach (bad[i]) begin
            wr(bad[i][10:8], bad[i][7:0]);
            @(posedge sys_clk);
            chk(config_invalid === 1'b1, "bad code");
            wr(bad[i][10:8], gv[bad[i][10:8]]);
        end
        @(posedge sys_clk);
        chk(config_invalid === 1'b0, "restored");
        $display("test validity done");
        // Coefficients: load, read back, refused writes, pointer restart.
        wr(3'h0, 8'h00);
        foreach (cb[i]) cb[i] = $urandom;
        for (int i = 0; i < 8; i++) wr(3'h2, cb[i]);
        look(7'h00, {cb[3], cb[2], cb[1], cb[0]});
        look(7'h01, {cb[7], cb[6], cb[5], cb[4]});
        rd(3'h2, 8'h00);
        wr(3'h0, 8'h10);
        for (int i = 0; i < 8; i++) rd(3'h2, cb[i]);
        for (int i = 8; i < 12; i++) wr(3'h2, cb[i]);
        wr(3'h0, 8'h00);
        look(7'h00, {cb[3], cb[2], cb[1], cb[0]});
        wr(3'h2, 8'h11);
        wr(3'h2, 8'h22);
        rd(3'h1, gv[1]);
        for (int i = 8; i < 12; i++) wr(3'h2, cb[i]);
        look(7'h00, {cb[11], cb[10], cb[9], cb[8]});
        chk(coef_load_full === 1'b0, "not full");
        repeat (516) wr(3'h2, 8'($urandom));
        chk(coef_load_full === 1'b1, "full");
        $display("test coefficients done");
        end_sim;
    end
endmodule
